// [rtl/scl_map.vh]
/*
 Register map for the system control low half: offsets, field positions,
 reset values. Assumes inclusion by scl_system_control.v only.
*/
`ifndef SCL_MAP_VH
`define SCL_MAP_VH
`define SCL_ADDR_W          8
`define SCL_SYSCTL_OFFSET   8'h00
`define SCL_CORE_EN_BIT     14
`define SCL_DIAG_BIT        12
`define SCL_TERM_BIT        11
`define SCL_UNALIGN_BIT     10
`define SCL_CORE_HOLD_BIT   7
`define SCL_DMA_RST_BIT     6
`define SCL_SYNC_HI         5
`define SCL_SYNC_LO         4
`define SCL_SYNC_RESET      2'h0
`define SCL_SYNC_TWO        2'h2
`define SCL_STRAP_SETTLE    2'h2
`define SCL_SIZE_BYTE       2'h0
`define SCL_SIZE_HALF       2'h1
`define SCL_SIZE_WORD       2'h2
`endif

// [rtl/scl_system_control.v]
/*
 System control register, low half: strap-loaded core bits, DMA diagnostic
 and soft reset, a storage-only bus bit, misaligned abort and the selectable
 synchroniser on the transfer acknowledge input.
 Assumes a one-cycle strobe register port on clock_in, a strap level that
 is stable around reset release, and a bus master that reports address and
 access size of each transfer on the same clock.
*/
// The plain strobed port and the register addresses were left to the implementer.
// Operation
// - The core enable bit is meant to be written zero and resets to the inverted strap line 26.
// - With the diagnostic bit set the DMA subsystem is held in reset and all context RAM is reachable.
// - With the diagnostic bit clear the DMA runs unless the soft reset bit is set, and only its control space is reachable.
// - The bus termination bit only stores what is written, resets to zero and drives nothing.
// - With the unaligned abort enable set a misaligned transfer gets a data abort, else never.
// - Misaligned means a halfword at an odd address or a word off a four byte boundary.
// - The core hold bit keeps the core in reset while one and resets to the inverted strap line 26.
// - The DMA soft reset bit holds only the DMA in reset while one and resets to zero.
// - Sync depth 00 and 01 give two flip-flop stages, 10 gives three, 11 is not to be used.
// - The three-stage setting adds exactly one cycle of acknowledge latency over two stages.
`include "scl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module scl_system_control #(
  parameter ADDR_W = `SCL_ADDR_W
) (
  input  wire              clock_in,
  input  wire              rstn_in,
  input  wire [ADDR_W-1:0] reg_addr_in,
  input  wire [31:0]       reg_wdata_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  output reg  [31:0]       reg_rdata_out,
  input  wire              strap_line_26_in,
  input  wire              xfer_valid_in,
  input  wire [1:0]        xfer_size_in,
  input  wire [1:0]        xfer_addr_lo_in,
  output wire              data_abort_out,
  input  wire              transfer_ack_n_in,
  output wire              transfer_ack_out,
  output wire              core_reset_out,
  output wire              dma_reset_out,
  output wire              dma_ctx_ram_access_out
);
  reg       core_enable_bit_reg;
  reg       dma_diag_access_reg;
  reg       bus_term_cfg_bit_reg;
  reg       unaligned_abort_enable_reg;
  reg       core_hold_in_reset_reg;
  reg       dma_soft_reset_reg;
  reg [1:0] ack_sync_depth_reg;
  reg       strap_meta_reg;
  reg       strap_sync_reg;
  reg       strap_loaded_reg;
  reg [1:0] strap_wait_reg;
  reg       ack_meta_reg;
  reg       ack_stage1_reg;
  reg       ack_stage2_reg;
  wire      sel_ctl;
  wire      misaligned;
  wire [31:0] ctl_value;

  function is_misaligned;
    input [1:0] size;
    input [1:0] lo;
    begin
      is_misaligned = ((size == `SCL_SIZE_HALF) && lo[0]) ||
                      ((size == `SCL_SIZE_WORD) && (lo != 2'h0));
    end
  endfunction

  assign sel_ctl = (reg_addr_in == `SCL_SYSCTL_OFFSET);

  // Reserved positions stay zero because they are never stored
  assign ctl_value = {16'h0000, 1'b0, core_enable_bit_reg, 1'b0,
                      dma_diag_access_reg, bus_term_cfg_bit_reg,
                      unaligned_abort_enable_reg, 2'h0,
                      core_hold_in_reset_reg, dma_soft_reset_reg,
                      ack_sync_depth_reg, 4'h0};

  // Strap is a pin: two flops before use, caught once after release
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end else begin
      strap_meta_reg <= strap_line_26_in;
      strap_sync_reg <= strap_meta_reg;
      // Count edges until the reset value has left both flops
      if (strap_wait_reg != `SCL_STRAP_SETTLE) begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_loaded_reg           <= 1'b0;
      core_enable_bit_reg        <= 1'b0;
      dma_diag_access_reg        <= 1'b0;
      bus_term_cfg_bit_reg       <= 1'b0;
      unaligned_abort_enable_reg <= 1'b0;
      core_hold_in_reset_reg     <= 1'b1;
      dma_soft_reset_reg         <= 1'b0;
      ack_sync_depth_reg         <= `SCL_SYNC_RESET;
    end else if (!strap_loaded_reg) begin
      // Third edge after release: strap has passed the synchroniser;
      // the flops' reset zeros would otherwise be taken as the strap
      if (strap_wait_reg == `SCL_STRAP_SETTLE) begin
        strap_loaded_reg       <= 1'b1;
        core_enable_bit_reg    <= ~strap_sync_reg;
        core_hold_in_reset_reg <= ~strap_sync_reg;
      end
    end else if (reg_wr_in && sel_ctl) begin
      core_enable_bit_reg        <= reg_wdata_in[`SCL_CORE_EN_BIT];
      dma_diag_access_reg        <= reg_wdata_in[`SCL_DIAG_BIT];
      bus_term_cfg_bit_reg       <= reg_wdata_in[`SCL_TERM_BIT];
      unaligned_abort_enable_reg <= reg_wdata_in[`SCL_UNALIGN_BIT];
      core_hold_in_reset_reg     <= reg_wdata_in[`SCL_CORE_HOLD_BIT];
      dma_soft_reset_reg         <= reg_wdata_in[`SCL_DMA_RST_BIT];
      ack_sync_depth_reg <= reg_wdata_in[`SCL_SYNC_HI:`SCL_SYNC_LO];
    end
  end

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in && sel_ctl) begin
      reg_rdata_out <= ctl_value;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // Acknowledge synchroniser; first stage feeds only the next flop
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_meta_reg   <= 1'b0;
      ack_stage1_reg <= 1'b0;
      ack_stage2_reg <= 1'b0;
    end else begin
      ack_meta_reg   <= ~transfer_ack_n_in;
      ack_stage1_reg <= ack_meta_reg;
      ack_stage2_reg <= ack_stage1_reg;
    end
  end

  // Setting 11 is unsupported and behaves as two stages
  assign transfer_ack_out = (ack_sync_depth_reg == `SCL_SYNC_TWO) ?
                            ack_stage2_reg : ack_stage1_reg;

  assign misaligned = is_misaligned(xfer_size_in, xfer_addr_lo_in);
  assign data_abort_out = xfer_valid_in && unaligned_abort_enable_reg &&
                          misaligned;

  // Core held while the hold bit is set or the strap is not yet taken
  assign core_reset_out = core_hold_in_reset_reg || !strap_loaded_reg;
  assign dma_reset_out  = dma_diag_access_reg || dma_soft_reset_reg;
  assign dma_ctx_ram_access_out = dma_diag_access_reg;
endmodule
`default_nettype wire

// [testbench/scl_sva.sv]
/* Port checker for the system control low half.
 Assumes a bind onto scl_system_control from the testbench top. */
`timescale 1ns/1ps
`default_nettype none
module scl_sva (
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        xfer_valid_in,
  input wire logic [1:0]  xfer_size_in,
  input wire logic [1:0]  xfer_addr_lo_in,
  input wire logic        data_abort_out,
  input wire logic        transfer_ack_n_in,
  input wire logic        transfer_ack_out,
  input wire logic        core_reset_out,
  input wire logic        dma_reset_out,
  input wire logic        dma_ctx_ram_access_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  wire logic wr0 = reg_wr_in && reg_addr_in == 8'h00;
  ctx_needs_rst_a: assert property (dma_ctx_ram_access_out |-> dma_reset_out)
    else $error("context access without dma reset");
  diag_set_a: assert property (wr0 && reg_wdata_in[12] |=>
    dma_ctx_ram_access_out && dma_reset_out) else $error("diag set ignored");
  diag_clear_a: assert property (wr0 && !reg_wdata_in[12] |=>
    !dma_ctx_ram_access_out) else $error("diag clear ignored");
  soft_rst_a: assert property (wr0 && !reg_wdata_in[12] |=>
    dma_reset_out == $past(reg_wdata_in[6])) else $error("dma reset wrong");
  core_hold_a: assert property (wr0 && reg_wdata_in[7] |=> core_reset_out)
    else $error("core hold ignored");
  rsvd_zero_a: assert property ({reg_rdata_out[13], reg_rdata_out[9:8],
    reg_rdata_out[3:0]} == 7'h00) else $error("reserved bit set");
  abort_idle_a: assert property (!xfer_valid_in |-> !data_abort_out)
    else $error("abort without transfer");
  abort_aligned_a: assert property (xfer_size_in == 2'h0 ||
    xfer_addr_lo_in == 2'h0 |-> !data_abort_out) else $error("abort aligned");
  ack_lat_a: assert property ($rose(transfer_ack_out) |->
    $past(transfer_ack_n_in, 2) == 1'b0) else $error("ack too early");
  cover property (data_abort_out);
  cover property ($rose(transfer_ack_out));
  cover property (dma_ctx_ram_access_out);
endmodule
`default_nettype wire

// [testbench/scl_bus_partner.sv]
/* Bus master and peripheral stand-in: starts a transfer, acknowledges it.
 Assumes one start pulse at a time and the synced ack fed back. */
`timescale 1ns/1ps
`default_nettype none
module scl_bus_partner (
  input  wire logic       clock_in,
  input  wire logic       start_in,
  input  wire logic [1:0] size_in,
  input  wire logic [1:0] lo_in,
  input  wire logic       ack_seen_in,
  output logic            valid_out = 1'b0,
  output logic [1:0]      size_out = 2'h0,
  output logic [1:0]      lo_out = 2'h0,
  output logic            ack_n_out = 1'b1
);
  // Ack stays low until seen, so a slow synchroniser never loses it
  always @(posedge clock_in) begin
    if (start_in) begin
      valid_out <= 1'b1;
      size_out <= size_in;
      lo_out <= lo_in;
      ack_n_out <= 1'b0;
    end else if (ack_seen_in) begin
      valid_out <= 1'b0;
      ack_n_out <= 1'b1;
      // Released lines wander so stale values are never trusted
      size_out <= ~size_out;
      lo_out <= ~lo_out;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_scl_system_control.sv]
/* Testbench for scl_system_control: register, strap and transfer tests.
 Assumes scl_sva and scl_bus_partner are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_scl_system_control;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, strap = 1, go = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [1:0]  sz = 2'h0, lo = 2'h0;
  wire logic [31:0] rdat;
  wire logic [1:0]  psz, plo;
  wire logic vld, abt, ack_n, ack, core, dma, ctx;
  int err_count = 0, total_checks = 0, n;
  always #5 clk = ~clk;
  scl_system_control u_scl_system_control (.clock_in(clk), .rstn_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .strap_line_26_in(strap), .xfer_valid_in(vld),
    .xfer_size_in(psz), .xfer_addr_lo_in(plo), .data_abort_out(abt),
    .transfer_ack_n_in(ack_n), .transfer_ack_out(ack), .core_reset_out(core),
    .dma_reset_out(dma), .dma_ctx_ram_access_out(ctx));
  scl_bus_partner u_scl_bus_partner (.clock_in(clk), .start_in(go),
    .size_in(sz), .lo_in(lo), .ack_seen_in(ack), .valid_out(vld),
    .size_out(psz), .lo_out(plo), .ack_n_out(ack_n));
  task chk(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk); wr <= 1; addr <= a; wd <= d;
    @(posedge clk); wr <= 0; #1;
  endtask
  task rreg(logic [7:0] a, logic [31:0] e);
    @(posedge clk); rd <= 1; addr <= a;
    @(posedge clk); rd <= 0; #1 chk("rdata", e, rdat);
  endtask
  task xfer(logic [1:0] s, logic [1:0] l, logic ea, int el);
    @(posedge clk); go <= 1; sz <= s; lo <= l;
    @(posedge clk); go <= 0; n = 0;
    #1 chk("abort", ea, abt);
    while (ack !== 1'b1 && n < 9) begin @(posedge clk); #1 n++; end
    chk("ack latency", el, n);
    repeat (5) @(posedge clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 2; s++) begin
      rst_n <= 0; strap <= s[0]; repeat (10) @(posedge clk);
      rst_n <= 1; repeat (4) @(posedge clk);
      rreg(8'h00, s ? 32'h0 : 32'h4080);
      chk("core reset", s == 0, core);
    end
    $display("test strap done");
    wreg(8'h00, 32'hFFFFFFFF);
    rreg(8'h00, 32'h00005CF0);
    chk("holds", 3'h7, {core, dma, ctx});
    wreg(8'h04, 32'h0);
    rreg(8'h00, 32'h00005CF0);
    rreg(8'h04, 32'h0);
    wreg(8'h00, 32'h00000040);
    chk("soft reset", 3'h2, {core, dma, ctx});
    wreg(8'h00, 32'h0);
    chk("all run", 3'h0, {core, dma, ctx});
    rreg(8'h00, 32'h0);
    $display("test regs done");
    for (int i = 0; i < 24; i++) begin
      wreg(8'h00, {21'h0, i[0], 4'h0, i[2:1], 4'h0});
      xfer(i[4:3], i[2:1], i[0] && ((i[4:3] == 1 && i[1]) ||
        (i[4:3] == 2 && i[2:1] != 0)), i[2:1] == 2 ? 3 : 2);
    end
    $display("test xfer done");
    print_verdict;
  end
  initial begin #100000; err_count++; print_verdict; end
endmodule
bind scl_system_control scl_sva u_scl_sva (.clock_in, .rstn_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .xfer_valid_in, .xfer_size_in,
  .xfer_addr_lo_in, .data_abort_out, .transfer_ack_n_in, .transfer_ack_out,
  .core_reset_out, .dma_reset_out, .dma_ctx_ram_access_out);
`default_nettype wire
